// File: iclc_defines.vh
`ifndef ICLC_DEFINES_VH
`define ICLC_DEFINES_VH
// ----------------------------------------
// Port addresses and unlock keys
// ----------------------------------------
`define ICLC_INDEX_PORT    16'h0302
`define ICLC_DATA_PORT     16'h0303
`define ICLC_KEY_A         8'h46
`define ICLC_KEY_B         8'h57
// ----------------------------------------
// Register indices and fields
// ----------------------------------------
`define ICLC_IDX_DEVSEL    8'h07
`define ICLC_IDX_LAMP      8'hf0
`define ICLC_LAMP_BIT      3
`define ICLC_DEV_LAMP      8'h01
`define ICLC_DEVSEL_RST    8'h00
`define ICLC_LAMP_RST      8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define ICLC_BLINK_MS      250
`define ICLC_CLK_KHZ       100000
`define ICLC_BLINK_CYC     (`ICLC_BLINK_MS * `ICLC_CLK_KHZ)
`endif

// File: iclc_blink.v
`timescale 1ns/100ps
// ----------------------------------------
// Free running blink divider
// ----------------------------------------
module iclc_blink #(
	parameter HALF_PERIOD = 25000000
) (
	// Clocking
	clk,
	rst,
	ce,
	// Output
	blink
);
	input  wire clk;
	input  wire rst;
	input  wire ce;
	output reg  blink;

	reg [31:0] cnt_reg;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 32'h00000000;
			blink   <= 1'b0;
		end else if (ce) begin
			if (cnt_reg >= HALF_PERIOD - 1) begin
				cnt_reg <= 32'h00000000;
				blink   <= ~blink;
			end else begin
				cnt_reg <= cnt_reg + 32'h00000001;
			end
		end
	end
endmodule // iclc_blink

// File: iclc_lamp_ctrl.v
`timescale 1ns/100ps
`include "iclc_defines.vh"
module iclc_lamp_ctrl #(
	parameter BLINK_HALF = `ICLC_BLINK_CYC
) (
	// Clocking
	clk,
	rst,
	ce,
	// Host I/O port access
	io_addr,
	io_wdata,
	io_wr,
	io_rd,
	io_rdata,
	// Board status
	boot_active,
	boot_done,
	fw_error_reset,
	disk_busy,
	green_lamp_line,
	green_two_line,
	// Lamps
	front_lamp_one_red,
	front_lamp_one_green,
	front_lamp_two_red,
	front_lamp_two_green,
	config_open
);
	input  wire        clk;
	input  wire        rst;
	input  wire        ce;
	input  wire [15:0] io_addr;
	input  wire [7:0]  io_wdata;
	input  wire        io_wr;
	input  wire        io_rd;
	output reg  [7:0]  io_rdata;
	input  wire        boot_active;
	input  wire        boot_done;
	input  wire        fw_error_reset;
	input  wire        disk_busy;
	input  wire        green_lamp_line;
	input  wire        green_two_line;
	output reg         front_lamp_one_red;
	output reg         front_lamp_one_green;
	output reg         front_lamp_two_red;
	output reg         front_lamp_two_green;
	output reg         config_open;

	// ----------------------------------------
	// Unlock sequencer
	// ----------------------------------------
	localparam ST_LOCKED  = 2'd0;
	localparam ST_HALF_IN = 2'd1;
	localparam ST_OPEN    = 2'd2;
	localparam ST_HALF_OUT = 2'd3;

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [7:0] index_reg;
	reg [7:0] devsel_reg;
	reg [7:0] lamp_reg;
	reg       err_latch_reg;
	wire      blink;
	wire      idx_wr;
	wire      dat_wr;
	wire      dat_rd;
	wire      is_open;
	wire      hit_devsel;
	wire      hit_lamp;

	// ----------------------------------------
	// Address and index decode
	// ----------------------------------------
	assign idx_wr  = io_wr && (io_addr == `ICLC_INDEX_PORT);
	assign dat_wr  = io_wr && (io_addr == `ICLC_DATA_PORT);
	assign dat_rd  = io_rd && (io_addr == `ICLC_DATA_PORT);
	assign is_open = (state_reg == ST_OPEN) || (state_reg == ST_HALF_OUT);

	// The lamp register answers only while the device number points at the
	// lamp function, so other functions may reuse the same index.
	assign hit_devsel = (index_reg == `ICLC_IDX_DEVSEL);
	assign hit_lamp   = (index_reg == `ICLC_IDX_LAMP) && (devsel_reg == `ICLC_DEV_LAMP);

	// ----------------------------------------
	// Key sequence next state
	// ----------------------------------------
	// Any other index write, except a repeat of the first key, breaks a half-entered key pair.
	always @* begin
		state_next = state_reg;
		if (idx_wr) begin
			case (state_reg)
				ST_LOCKED: begin
					if (io_wdata == `ICLC_KEY_A)
						state_next = ST_HALF_IN;
				end
				ST_HALF_IN: begin
					if (io_wdata == `ICLC_KEY_B)
						state_next = ST_OPEN;
					else if (io_wdata != `ICLC_KEY_A)
						state_next = ST_LOCKED;
				end
				ST_OPEN: begin
					if (io_wdata == `ICLC_KEY_B)
						state_next = ST_HALF_OUT;
				end
				ST_HALF_OUT: begin
					if (io_wdata == `ICLC_KEY_A)
						state_next = ST_LOCKED;
					else if (io_wdata != `ICLC_KEY_B)
						state_next = ST_OPEN;
				end
				default: state_next = ST_LOCKED;
			endcase
		end
	end

	// ----------------------------------------
	// Sequencer state and index latch
	// ----------------------------------------
	// The closing key bytes also land in the index latch; harmless, since neither
	// key value matches a mapped index.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_LOCKED;
			index_reg <= 8'h00;
		end else if (ce) begin
			state_reg <= state_next;
			if (idx_wr && is_open)
				index_reg <= io_wdata;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			devsel_reg <= `ICLC_DEVSEL_RST;
		end else if (ce) begin
			if (dat_wr && is_open && hit_devsel)
				devsel_reg <= io_wdata;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			lamp_reg <= `ICLC_LAMP_RST;
		end else if (ce) begin
			if (dat_wr && is_open && hit_lamp)
				lamp_reg <= io_wdata;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// A closed port reads as zero rather than holding the last value, so a
	// probe before unlocking cannot see register contents.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			io_rdata <= 8'h00;
		end else if (ce && dat_rd) begin
			if (!is_open) begin
				io_rdata <= 8'h00;
			end else if (hit_devsel) begin
				io_rdata <= devsel_reg;
			end else if (hit_lamp) begin
				io_rdata <= lamp_reg;
			end else begin
				io_rdata <= 8'h00;
			end
		end
	end

	// ----------------------------------------
	// Lamp drivers
	// ----------------------------------------
	iclc_blink #(
		.HALF_PERIOD(BLINK_HALF)
	) u_blink (
		.clk   (clk),
		.rst   (rst),
		.ce    (ce),
		.blink (blink)
	);

	// ----------------------------------------
	// Firmware error latch
	// ----------------------------------------
	// The error indication is held until the forced reset clears it, so a
	// short error pulse still leaves the lamp lit long enough to be seen.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			err_latch_reg <= 1'b0;
		end else if (ce) begin
			if (fw_error_reset)
				err_latch_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// Lamp outputs
	// ----------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			front_lamp_one_red   <= 1'b0;
			front_lamp_one_green <= 1'b0;
			front_lamp_two_red   <= 1'b0;
			front_lamp_two_green <= 1'b0;
			config_open          <= 1'b0;
		end else if (ce) begin
			front_lamp_one_red   <= lamp_reg[`ICLC_LAMP_BIT] | fw_error_reset
				| err_latch_reg;
			front_lamp_one_green <= boot_done ? 1'b1 :
				(boot_active ? blink : green_lamp_line);
			front_lamp_two_red   <= disk_busy;
			front_lamp_two_green <= green_two_line;
			config_open          <= (state_next == ST_OPEN) || (state_next == ST_HALF_OUT);
		end
	end
endmodule // iclc_lamp_ctrl

// File: iclc_assertions.sv
`timescale 1ns/100ps
module iclc_checker (
	input wire        clk, rst, ce, io_wr, io_rd, config_open,
	input wire        boot_active, boot_done, fw_error_reset, disk_busy,
	input wire        green_lamp_line, green_two_line,
	input wire        front_lamp_one_red, front_lamp_one_green,
	input wire        front_lamp_two_red, front_lamp_two_green,
	input wire [15:0] io_addr,
	input wire [7:0]  io_wdata, io_rdata
);
	default clocking @(posedge clk); endclocking
	// A frozen clock enable would hold every lamp, so those cycles prove nothing.
	default disable iff (rst || !ce);
	property p_disk;
		!$past(rst) && $past(ce) |-> front_lamp_two_red == $past(disk_busy);
	endproperty
	a_disk: assert property (p_disk) else $error("drive lamp wrong");
	property p_grn2;
		!$past(rst) && $past(ce) |-> front_lamp_two_green == $past(green_two_line);
	endproperty
	a_grn2: assert property (p_grn2) else $error("green two wrong");
	property p_fw; fw_error_reset |-> ##2 front_lamp_one_red; endproperty
	a_fw: assert property (p_fw) else $error("error lamp dark");
	property p_boot; boot_done ##1 boot_done |-> front_lamp_one_green; endproperty
	a_boot: assert property (p_boot) else $error("boot lamp dark");
	property p_gpio;
		!$past(rst) && $past(ce) && !$past(boot_active || boot_done) |->
			front_lamp_one_green == $past(green_lamp_line);
	endproperty
	a_gpio: assert property (p_gpio) else $error("green one wrong");
	property p_open;
		$rose(config_open) |-> $past(io_wr && io_addr == 16'h0302 && io_wdata == 8'h57);
	endproperty
	a_open: assert property (p_open) else $error("bad open");
	property p_close;
		$fell(config_open) |-> $past(io_wr && io_addr == 16'h0302 && io_wdata == 8'h46);
	endproperty
	a_close: assert property (p_close) else $error("bad close");
	property p_shut; !config_open && io_rd && io_addr == 16'h0303 |=> io_rdata == 8'h00; endproperty
	a_shut: assert property (p_shut) else $error("closed read leaked");
	c_open: cover property ($rose(config_open));
	c_red: cover property ($rose(front_lamp_one_red));
	c_disk: cover property (disk_busy ##1 front_lamp_two_red);
endmodule // iclc_checker
bind iclc_lamp_ctrl iclc_checker u_chk (.*);

// File: iclc_host.sv
`timescale 1ns/100ps
module iclc_host (
	input wire        clk,
	input wire [7:0]  io_rdata,
	output reg [15:0] io_addr,
	output reg [7:0]  io_wdata,
	output reg        io_wr, io_rd
);
	initial begin
		io_addr = 16'h0000;
		io_wdata = 8'h00;
		io_wr = 1'b0;
		io_rd = 1'b0;
	end
	// Key pairs and device selection go out as single strobed writes.
	task wr(input [15:0] a, input [7:0] d);
		@(posedge clk);
		#1 {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
		@(posedge clk);
		#1 {io_addr, io_wdata, io_wr} = {~a, ~d, 1'b0};
	endtask
	task rd(input [15:0] a, output [7:0] d);
		@(posedge clk);
		#1 {io_addr, io_rd} = {a, 1'b1};
		@(posedge clk);
		#1 {io_addr, io_rd} = {~a, 1'b0};
		@(posedge clk);
		#1 d = io_rdata;
	endtask
endmodule // iclc_host

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
	reg         clk = 0, rst = 1, ce = 1, boot_active = 0, boot_done = 0;
	reg         fw_error_reset = 0, disk_busy = 0, green_lamp_line = 0, green_two_line = 0;
	wire [15:0] io_addr;
	wire [7:0]  io_wdata, io_rdata;
	wire        io_wr, io_rd, config_open;
	wire        front_lamp_one_red, front_lamp_one_green, front_lamp_two_red, front_lamp_two_green;
	reg  [7:0]  d;
	integer     mismatches = 0, tests_run = 0;
	always #5 clk = ~clk;
	iclc_host host (.*);
	iclc_lamp_ctrl #(.BLINK_HALF(4)) uut (.*);
	task ck(input [7:0] g, e);
		tests_run = tests_run + 1;
		if (g !== e) begin
			mismatches = mismatches + 1;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task step(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task results;
		$display("%0d checks, %0d mismatches", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		step(10);
		rst = 0;
		host.rd(16'h0303, d); ck(d, 8'h00);
		host.wr(16'h0302, 8'h57);
		host.wr(16'h0302, 8'h46); ck(config_open, 0);
		host.wr(16'h0302, 8'h46);
		host.wr(16'h0302, 8'h57); ck(config_open, 1);
		host.wr(16'h0302, 8'h07);
		host.wr(16'h0303, 8'h01);
		host.rd(16'h0303, d); ck(d, 8'h01);
		host.wr(16'h0302, 8'hf0);
		host.rd(16'h0303, d); ck(d, 8'h00);
		host.wr(16'h0303, d | 8'h08); step(2); ck(front_lamp_one_red, 1);
		host.rd(16'h0303, d); ck(d, 8'h08);
		host.wr(16'h0303, d & 8'hf7); step(2); ck(front_lamp_one_red, 0);
		$display("register test done");
		host.wr(16'h0302, 8'h57);
		host.wr(16'h0302, 8'h46); ck(config_open, 0);
		host.wr(16'h0303, 8'h08); step(2); ck(front_lamp_one_red, 0);
		host.rd(16'h0303, d); ck(d, 8'h00);
		$display("closed test done");
		{ce, disk_busy, green_two_line} = 3'b011;
		step(2); ck({front_lamp_two_red, front_lamp_two_green}, 8'h00);
		ce = 1;
		step(2); ck({front_lamp_two_red, front_lamp_two_green}, 8'h03);
		{disk_busy, green_two_line, green_lamp_line} = 3'b001;
		step(2); ck({front_lamp_two_red, front_lamp_one_green}, 8'h01);
		{green_lamp_line, boot_done} = 2'b01;
		step(2); ck(front_lamp_one_green, 1);
		{boot_done, boot_active} = 2'b01;
		d = 8'h00;
		repeat (12) begin
			step(1);
			d = d + front_lamp_one_green;
		end
		ck(d != 8'h00 && d != 8'h0c, 1);
		{boot_active, fw_error_reset} = 2'b01;
		step(1);
		fw_error_reset = 0;
		step(3); ck(front_lamp_one_red, 1);
		rst = 1;
		step(2);
		rst = 0;
		step(2); ck({front_lamp_one_red, config_open}, 8'h00);
		$display("lamp test done");
		results;
	end
	initial begin
		#20000;
		mismatches = mismatches + 1;
		results;
	end
endmodule // tb_top
